// file: rio_mapper.sv
// Remote I/O mapper: contact inputs to commands, status to contact outputs
//
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ps

module rio_mapper #(
	parameter int unsigned REPEAT_CYCLES = rio_pkg::REPEAT_CYC
) (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire rio_pkg::rio_wb_req_s          wb_req,
	output logic                               wb_ack,
	output logic [31:0]                        wb_dat,
	input  wire logic [rio_pkg::N_IN-1:0]      remote_in,
	input  wire rio_pkg::rio_stat_s            stat,
	output rio_pkg::rio_cmd_s                  cmd,
	output logic [rio_pkg::SP_W-1:0]           setpoint,
	output logic [rio_pkg::N_OUT-1:0]          rout,
	output logic [rio_pkg::N_OUT-1:0]          rout_oe
);
	import rio_pkg::*;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [SP_W-1:0] sp_step(
		input logic [SP_W-1:0] sp,
		input logic [SP_W-1:0] mn,
		input logic [SP_W-1:0] mx,
		input logic            up
	);
		logic [SP_W:0] t;
		t = {1'b0, sp};
		if (up) begin
			t = {1'b0, sp} + SP_STEP;
			if (t > {1'b0, mx})
				t = {1'b0, mx};
		end else if ({1'b0, sp} < ({1'b0, mn} + SP_STEP)) begin
			t = {1'b0, mn};
		end else begin
			t = {1'b0, sp} - SP_STEP;
		end
		return t[SP_W-1:0];
	endfunction

	function automatic logic [31:0] wmerge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0]  sel
	);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic [7:0] reg_adr(
		input logic [7:0] base,
		input int         idx
	);
		return 8'(int'(base) + 4 * idx);
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	rio_state_s        s;
	rio_state_s        n;
	logic              on_any;
	logic              off_any;
	logic              p1_any;
	logic              p2_any;
	logic              ar_any;
	logic [N_IN-1:0]   pa;
	logic [N_IN-1:0]   pup;
	logic [2:0]        psel;
	logic              step;
	logic              step_up;
	logic              bus_wr;
	logic              lvl;
	logic              rise;
	logic              fall;
	logic              hit;
	logic              cond;
	logic [2:0]        md;
	logic [31:0]       rv;
	logic [31:0]       wv;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		n = s;
		n.cmd = '0;
		on_any = 1'b0;
		off_any = 1'b0;
		p1_any = 1'b0;
		p2_any = 1'b0;
		ar_any = 1'b0;
		pa = '0;
		pup = '0;
		psel = PSEL_NONE;
		step = 1'b0;
		step_up = 1'b0;
		lvl = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		hit = 1'b0;
		cond = 1'b0;
		md = '0;
		rv = '0;
		wv = '0;
		// Contacts are asynchronous to clk
		n.sync1 = remote_in;
		n.sync2 = s.sync1;
		n.prev = s.sync2;

		for (int i = 0; i < N_IN; i++) begin
			lvl = s.sync2[i];
			rise = lvl & ~s.prev[i];
			fall = ~lvl & s.prev[i];
			md = s.in_cfg[i].mode;
			hit = 1'b0;
			if (s.remote_en) begin
				case (s.in_cfg[i].ch)
				ICH_RF: begin
					case (md)
					RF_RISE_ACT:   on_any = on_any | rise;
					RF_FALL_ACT:   on_any = on_any | fall;
					RF_RISE_DEACT: off_any = off_any | rise;
					RF_FALL_DEACT: off_any = off_any | fall;
					RF_RISE_TOG: begin
						if (rise) begin
							on_any = on_any | ~s.tog[i];
							off_any = off_any | s.tog[i];
							n.tog[i] = ~s.tog[i];
						end
					end
					RF_FALL_TOG: begin
						if (fall) begin
							off_any = off_any | ~s.tog[i];
							on_any = on_any | s.tog[i];
							n.tog[i] = ~s.tog[i];
						end
					end
					RF_LVL_ON: begin
						// Re-requests while the stage disagrees
						if (lvl != stat.rf_stage_on) begin
							on_any = on_any | lvl;
							off_any = off_any | ~lvl;
						end
					end
					default: begin
						if (lvl == stat.rf_stage_on) begin
							on_any = on_any | ~lvl;
							off_any = off_any | lvl;
						end
					end
					endcase
				end
				ICH_P1, ICH_P2: begin
					case (md)
					PS_RISE: hit = rise;
					PS_FALL: hit = fall;
					PS_HIGH: hit = lvl;
					default: hit = ~lvl;
					endcase
					if (s.in_cfg[i].ch == ICH_P1)
						p1_any = p1_any | hit;
					else
						p2_any = p2_any | hit;
				end
				ICH_PWR: begin
					// Edge modes step on assertion, so they share level logic
					pa[i] = lvl ^ md[0];
					pup[i] = ~md[1];
				end
				ICH_ARST: begin
					if (md == AR_FALL)
						ar_any = ar_any | fall;
					else
						ar_any = ar_any | rise;
				end
				default: ;
				endcase
			end
		end

		// ************************************************************
		// Power stepping
		// ************************************************************
		for (int i = N_IN - 1; i >= 0; i--) begin
			if (pa[i])
				psel = 3'(i);
		end
		if (psel != PSEL_NONE) begin
			step_up = pup[psel];
			if (psel != s.pwr_idx) begin
				step = 1'b1;
				n.rep_cnt = '0;
			end else if (s.rep_cnt == RC_W'(REPEAT_CYCLES - 1)) begin
				step = 1'b1;
				n.rep_cnt = '0;
			end else begin
				n.rep_cnt = s.rep_cnt + 1'b1;
			end
		end else begin
			n.rep_cnt = '0;
		end
		n.pwr_idx = psel;
		if (step)
			n.setpoint = sp_step(s.setpoint, s.sp_min, s.sp_max,
				step_up);

		// Off beats on and preset 1 beats preset 2 when both fire
		n.cmd.rf_off = off_any;
		n.cmd.rf_on = on_any & ~off_any;
		n.cmd.preset1 = p1_any;
		n.cmd.preset2 = p2_any & ~p1_any;
		n.cmd.pwr_up = step & step_up;
		n.cmd.pwr_dn = step & ~step_up;
		n.cmd.alarm_reset = ar_any;

		// ************************************************************
		// Outputs
		// ************************************************************
		for (int o = 0; o < N_OUT; o++) begin
			case (s.out_cfg[o].ch)
			OCH_RF:    cond = stat.rf_stage_on;
			OCH_FAULT: cond = stat.rf_fault;
			OCH_P1:    cond = ~stat.preset2_active;
			OCH_P2:    cond = stat.preset2_active;
			OCH_REM:   cond = s.remote_en;
			OCH_ALM:   cond = stat.alarm_any;
			default:   cond = 1'b0;
			endcase
			if (s.out_cfg[o].ch == OCH_P1 || s.out_cfg[o].ch == OCH_P2) begin
				n.rout[o] = 1'b0;
				n.rout_oe[o] = cond;
			end else begin
				n.rout[o] = s.out_cfg[o].act_high ? cond : ~cond;
				n.rout_oe[o] = 1'b1;
			end
		end

		// ************************************************************
		// Wishbone slave
		// ************************************************************
		case (wb_req.adr)
		A_CTRL:   rv = {31'h0, s.remote_en};
		A_STATUS: begin
			rv[N_IN-1:0] = s.sync2;
			rv[ST_RF_BIT +: 4] = stat;
			rv[ST_OUT_LSB +: N_OUT] = s.rout;
			rv[ST_IDX_LSB +: 3] = s.pwr_idx;
		end
		A_SETPT:  rv = 32'(s.setpoint);
		A_SPMIN:  rv = 32'(s.sp_min);
		A_SPMAX:  rv = 32'(s.sp_max);
		default: begin
			for (int i = 0; i < N_IN; i++) begin
				if (wb_req.adr == reg_adr(A_IN0, i)) begin
					rv[CH_LSB +: 3] = s.in_cfg[i].ch;
					rv[IN_MODE_LSB +: 3] = s.in_cfg[i].mode;
				end
			end
			for (int o = 0; o < N_OUT; o++) begin
				if (wb_req.adr == reg_adr(A_OUT0, o)) begin
					rv[CH_LSB +: 3] = s.out_cfg[o].ch;
					rv[OUT_POL_BIT] = s.out_cfg[o].act_high;
				end
			end
		end
		endcase
		n.ack = wb_req.cyc & wb_req.stb & ~s.ack;
		if (n.ack)
			n.rdat = rv;
		// Writes land on the edge where the master sees ack
		bus_wr = wb_req.cyc & wb_req.stb & wb_req.we & s.ack;
		wv = wmerge(rv, wb_req.dat, wb_req.sel);
		if (bus_wr) begin
			case (wb_req.adr)
			A_CTRL:  n.remote_en = wv[0];
			A_SETPT: n.setpoint = wv[SP_W-1:0];
			A_SPMIN: n.sp_min = wv[SP_W-1:0];
			A_SPMAX: n.sp_max = wv[SP_W-1:0];
			default: begin
				for (int i = 0; i < N_IN; i++) begin
					if (wb_req.adr == reg_adr(A_IN0, i)) begin
						n.in_cfg[i].ch = wv[CH_LSB +: 3];
						n.in_cfg[i].mode = wv[IN_MODE_LSB +: 3];
					end
				end
				for (int o = 0; o < N_OUT; o++) begin
					if (wb_req.adr == reg_adr(A_OUT0, o)) begin
						n.out_cfg[o].ch = wv[CH_LSB +: 3];
						n.out_cfg[o].act_high = wv[OUT_POL_BIT];
					end
				end
			end
			endcase
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.in_cfg <= IN_CFG_RST;
			s.setpoint <= SP_RST;
			s.sp_min <= SP_MIN_RST;
			s.sp_max <= SP_MAX_RST;
			s.pwr_idx <= PSEL_NONE;
			s.rout <= ROUT_RST;
			s.rout_oe <= OE_RST;
		end else begin
			s <= n;
		end
	end

	assign wb_ack = s.ack;
	assign wb_dat = s.rdat;
	assign cmd = s.cmd;
	assign setpoint = s.setpoint;
	assign rout = s.rout;
	assign rout_oe = s.rout_oe;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sync_depth_a: assert property (
		!rst |-> ##2 s.sync2 == $past(remote_in, 2))
		else $error("Input synchroniser depth is not two");

	remote_gate_a: assert property (
		!s.remote_en |=> s.cmd == '0)
		else $error("Command issued while remote disabled");

	rf_fall_act_a: assert property (
		(s.remote_en && s.in_cfg[0].ch == ICH_RF &&
		 s.in_cfg[0].mode == RF_FALL_ACT && s.prev[0] && !s.sync2[0])
		|=> (s.cmd.rf_on || s.cmd.rf_off))
		else $error("Falling edge did not request RF");

	pwr_lowest_a: assert property (
		(psel != PSEL_NONE) |-> (pa & ((7'h01 << psel) - 7'h01)) == '0)
		else $error("Power input chosen is not the lowest");

	pwr_repeat_a: assert property (
		(psel != PSEL_NONE && psel == s.pwr_idx &&
		 s.rep_cnt == RC_W'(REPEAT_CYCLES - 1))
		|=> (s.cmd.pwr_up || s.cmd.pwr_dn) && s.rep_cnt == '0)
		else $error("Held power input did not repeat");

	pwr_step_a: assert property (
		(step && step_up && !bus_wr &&
		 ({1'b0, s.setpoint} + SP_STEP) <= {1'b0, s.sp_max})
		|=> s.setpoint == $past(s.setpoint) + SP_W'(SP_STEP))
		else $error("Power step is not one percent");

	pwr_floor_a: assert property (
		(step && !step_up && !bus_wr &&
		 {1'b0, s.setpoint} < ({1'b0, s.sp_min} + SP_STEP))
		|=> s.setpoint == $past(s.sp_min))
		else $error("Power step went below minimum");

	preset_open_a: assert property (
		(s.out_cfg[3].ch == OCH_P2 && !stat.preset2_active)
		##1 (s.out_cfg[3].ch == OCH_P2) |-> !s.rout_oe[3])
		else $error("Inactive preset output is driven");

	out_polarity_a: assert property (
		(s.out_cfg[5].ch == OCH_ALM && s.out_cfg[5].act_high &&
		 stat.alarm_any) |=> s.rout[5] && s.rout_oe[5])
		else $error("Active-high alarm output not high");

	alarm_edge_a: assert property (
		(s.remote_en && s.in_cfg[6].ch == ICH_ARST &&
		 s.in_cfg[6].mode == AR_FALL && s.prev[6] && !s.sync2[6])
		|=> s.cmd.alarm_reset)
		else $error("Falling edge missed alarm reset");

	wb_ack_pulse_a: assert property (
		s.ack |=> !s.ack)
		else $error("Bus ack held longer than one cycle");

	rf_on_c: cover property (s.cmd.rf_on ##[1:100] s.cmd.rf_off);
	pwr_rep_c: cover property (s.cmd.pwr_up ##1 !s.cmd.pwr_up [*2]);
	preset_c: cover property (s.cmd.preset2 ##1 s.cmd.preset1);
	alarm_c: cover property (s.cmd.alarm_reset);

endmodule

// file: rio_pkg.sv
// Constants, field layouts and carrier types of the remote I/O mapper
package rio_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int N_IN  = 7;
	localparam int N_OUT = 6;
	localparam int SP_W  = 10;
	localparam int RC_W  = 27;

	// ****************************************************************
	// Channel codes
	// ****************************************************************
	localparam logic [2:0] ICH_NONE  = 3'h0;
	localparam logic [2:0] ICH_RF    = 3'h1;
	localparam logic [2:0] ICH_P1    = 3'h2;
	localparam logic [2:0] ICH_P2    = 3'h3;
	localparam logic [2:0] ICH_PWR   = 3'h4;
	localparam logic [2:0] ICH_ARST  = 3'h5;
	localparam logic [2:0] OCH_NONE  = 3'h0;
	localparam logic [2:0] OCH_RF    = 3'h1;
	localparam logic [2:0] OCH_FAULT = 3'h2;
	localparam logic [2:0] OCH_P1    = 3'h3;
	localparam logic [2:0] OCH_P2    = 3'h4;
	localparam logic [2:0] OCH_REM   = 3'h5;
	localparam logic [2:0] OCH_ALM   = 3'h6;

	// ****************************************************************
	// Input modes; power codes: bit0 set = low/falling, bit1 set = down
	// ****************************************************************
	localparam logic [2:0] RF_RISE_ACT   = 3'h0;
	localparam logic [2:0] RF_FALL_ACT   = 3'h1;
	localparam logic [2:0] RF_RISE_DEACT = 3'h2;
	localparam logic [2:0] RF_FALL_DEACT = 3'h3;
	localparam logic [2:0] RF_RISE_TOG   = 3'h4;
	localparam logic [2:0] RF_FALL_TOG   = 3'h5;
	localparam logic [2:0] RF_LVL_ON     = 3'h6;
	localparam logic [2:0] RF_LVL_OFF    = 3'h7;
	localparam logic [2:0] PS_RISE       = 3'h0;
	localparam logic [2:0] PS_FALL       = 3'h1;
	localparam logic [2:0] PS_HIGH       = 3'h2;
	localparam logic [2:0] PW_RISE_INC   = 3'h0;
	localparam logic [2:0] PW_FALL_INC   = 3'h1;
	localparam logic [2:0] PW_FALL_DEC   = 3'h3;
	localparam logic [2:0] AR_FALL       = 3'h1;

	// ****************************************************************
	// Register offsets and field positions
	// ****************************************************************
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_SETPT  = 8'h08;
	localparam logic [7:0] A_SPMIN  = 8'h0c;
	localparam logic [7:0] A_SPMAX  = 8'h10;
	localparam logic [7:0] A_IN0    = 8'h20;
	localparam logic [7:0] A_OUT0   = 8'h40;
	localparam int CH_LSB      = 0;
	localparam int IN_MODE_LSB = 3;
	localparam int OUT_POL_BIT = 4;
	localparam int ST_RF_BIT   = 8;
	localparam int ST_OUT_LSB  = 16;
	localparam int ST_IDX_LSB  = 24;

	// ****************************************************************
	// Reset values and timing
	// ****************************************************************
	localparam logic [N_IN*6-1:0] IN_CFG_RST =
		{18'h0, 6'h1c, 6'h0c, 6'h19, 6'h09};
	localparam logic [SP_W-1:0] SP_RST     = 10'h1f4;
	localparam logic [SP_W-1:0] SP_MIN_RST = 10'h000;
	localparam logic [SP_W-1:0] SP_MAX_RST = 10'h3e8;
	localparam logic [SP_W:0]   SP_STEP    = 11'h00a;
	localparam logic [N_OUT-1:0] ROUT_RST  = 6'h3f;
	localparam logic [N_OUT-1:0] OE_RST    = 6'h3f;
	localparam logic [2:0] PSEL_NONE       = 3'h7;
	localparam int REPEAT_MS  = 500;
	localparam int CLK_KHZ    = 125000;
	localparam int REPEAT_CYC = REPEAT_MS * CLK_KHZ;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	typedef struct packed {
		logic [2:0] mode;
		logic [2:0] ch;
	} rio_in_cfg_s;
	typedef struct packed {
		logic       act_high;
		logic [2:0] ch;
	} rio_out_cfg_s;
	typedef struct packed {
		logic rf_on;
		logic rf_off;
		logic preset1;
		logic preset2;
		logic pwr_up;
		logic pwr_dn;
		logic alarm_reset;
	} rio_cmd_s;
	typedef struct packed {
		logic rf_stage_on;
		logic rf_fault;
		logic alarm_any;
		logic preset2_active;
	} rio_stat_s;
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} rio_wb_req_s;
	typedef struct packed {
		logic [N_IN-1:0]            sync1;
		logic [N_IN-1:0]            sync2;
		logic [N_IN-1:0]            prev;
		logic [N_IN-1:0]            tog;
		rio_in_cfg_s [N_IN-1:0]     in_cfg;
		rio_out_cfg_s [N_OUT-1:0]   out_cfg;
		logic                       remote_en;
		logic [SP_W-1:0]            setpoint;
		logic [SP_W-1:0]            sp_min;
		logic [SP_W-1:0]            sp_max;
		logic [2:0]                 pwr_idx;
		logic [RC_W-1:0]            rep_cnt;
		rio_cmd_s                   cmd;
		logic [N_OUT-1:0]           rout;
		logic [N_OUT-1:0]           rout_oe;
		logic                       ack;
		logic [31:0]                rdat;
	} rio_state_s;

endpackage

// file: rio_station.sv
// Station remote-control equipment: contact drivers and pulled-up lines
`timescale 1ns/1ps

module rio_station (
	input  wire logic [0:0] clk,
	input  wire logic [5:0] rout,
	input  wire logic [5:0] rout_oe,
	output logic      [6:0] remote_in,
	output logic      [5:0] line
);
	// ****************************************************************
	// Lines and contacts
	// ****************************************************************
	// A released collector floats up to the pull-up, never the last level
	assign line = (rout & rout_oe) | ~rout_oe;

	initial remote_in = 7'h7f;

	// Contacts move just after an edge and rest for hold cycles
	task automatic put(input logic [6:0] v, input int hold);
		@(posedge clk);
		remote_in <= v;
		repeat (hold) @(posedge clk);
	endtask
endmodule

// file: test_remote_io_control_mapper.sv
// Self-checking bench of the remote I/O mapper
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
	mismatches++; $display("wrong value at %0t: got %h expected %h", \
	$time, (a), (e)); end end

module test_remote_io_control_mapper;
	import rio_pkg::*;
	// ****************************************************************
	// Signals
	// ****************************************************************
	// Short repeat keeps the held-input test to a few dozen cycles
	localparam int RPT = 20;
	localparam logic [6:0] C_ON = 7'h40, C_OFF = 7'h20, C_P1 = 7'h10;
	localparam logic [6:0] C_P2 = 7'h08, C_UP = 7'h04, C_DN = 7'h02;
	localparam logic [6:0] C_AR = 7'h01;
	logic        clk, rst, wb_ack, on;
	logic [31:0] wb_dat, rv;
	rio_wb_req_s req;
	logic [6:0]  remote_in;
	rio_stat_s   stat;
	rio_cmd_s    cmd;
	logic [9:0]  setpoint, esp;
	logic [5:0]  rout, rout_oe, line;
	int          mismatches, check_count;
	logic [31:0] rq[$];
	logic [16:0] eq[$];
	logic [31:0] re;
	logic [16:0] ee;

	rio_mapper #(.REPEAT_CYCLES(RPT)) dut (.clk(clk), .rst(rst),
		.wb_req(req), .wb_ack(wb_ack), .wb_dat(wb_dat),
		.remote_in(remote_in), .stat(stat), .cmd(cmd),
		.setpoint(setpoint), .rout(rout), .rout_oe(rout_oe));
	rio_station st (.clk(clk), .rout(rout), .rout_oe(rout_oe),
		.remote_in(remote_in), .line(line));

	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req <= '{1'b1, 1'b1, w, a, 4'hf, d};
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50) mismatches++;
		req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic ev(input logic [6:0] c);
		eq.push_back({c, esp});
	endtask
	task automatic pulse(input int i);
		st.put(7'h7f & ~(7'h01 << i), 8);
		st.put(7'h7f, 8);
	endtask
	task automatic cfg(input int i, input logic [5:0] v,
		input logic [6:0] c);
		bus(1'b1, A_IN0 + 8'(4 * i), {26'h0, v});
		if (c !== 7'h0) ev(c);
		pulse(i);
	endtask
	task automatic stage(input logic v);
		@(posedge clk);
		stat.rf_stage_on <= v;
	endtask
	task automatic note(input string s);
		$display("test %s done", s);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****************************************************************
	// Monitor: oldest note against each result
	// ****************************************************************
	always @(posedge clk) begin
		#1;
		if (wb_ack === 1'b1 && req.we === 1'b0) begin
			re = rq.pop_front();
			`CHK(wb_dat, re)
		end
		if (cmd !== '0) begin
			ee = eq.pop_front();
			`CHK({cmd, setpoint}, ee)
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		give_verdict();
	end

	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		rst = 1;
		req = '0;
		stat = '0;
		esp = SP_RST;
		void'($urandom(54702));
		repeat (12) @(posedge clk);
		rst <= 0;
		`CHK(rout, ROUT_RST)
		`CHK(rout_oe, OE_RST)
		rd(A_CTRL, 32'h0);
		rd(A_SETPT, {22'h0, SP_RST});
		rd(A_SPMAX, 32'h3e8);
		rd(A_IN0, 32'h09);
		rd(A_IN0 + 8'h04, 32'h19);
		rd(A_IN0 + 8'h08, 32'h0c);
		rd(A_IN0 + 8'h0c, 32'h1c);
		rd(8'h80, 32'h0);
		pulse(0);
		note("reset");
		bus(1'b1, A_CTRL, 32'h1);
		ev(C_ON);
		pulse(0);
		ev(C_OFF);
		pulse(1);
		esp = 10'h1fe; ev(C_UP);
		esp = 10'h208; ev(C_UP);
		esp = 10'h212; ev(C_UP);
		st.put(7'h7b, 50);
		st.put(7'h7f, 8);
		esp = 10'h21c; ev(C_UP);
		st.put(7'h73, 10);
		st.put(7'h7f, 8);
		bus(1'b1, A_SPMAX, 32'h220);
		esp = 10'h220; ev(C_UP);
		pulse(2);
		bus(1'b1, A_SPMIN, 32'h21a);
		esp = 10'h21a; ev(C_DN);
		pulse(3);
		rv = $urandom % 32'h220;
		bus(1'b1, A_SETPT, rv);
		esp = rv[9:0];
		rd(A_SETPT, rv);
		note("power");
		for (int m = 0; m < 6; m++) begin
			for (int k = 0; k < 2; k++) begin
				on = m < 2 || (m == 4 && k == 0) || (m == 5 && k == 1);
				cfg(m < 4 ? 4 : m, {3'(m), ICH_RF}, on ? C_ON : C_OFF);
			end
		end
		stage(1'b1);
		bus(1'b1, A_IN0 + 8'h10, {26'h0, RF_LVL_ON, ICH_RF});
		ev(C_ON);
		stage(1'b0);
		stage(1'b1);
		bus(1'b1, A_IN0 + 8'h10, 32'h0);
		stage(1'b0);
		bus(1'b1, A_IN0 + 8'h10, {26'h0, RF_LVL_OFF, ICH_RF});
		ev(C_OFF);
		stage(1'b1);
		stage(1'b0);
		bus(1'b1, A_IN0 + 8'h10, 32'h0);
		note("rf modes");
		cfg(4, {PS_RISE, ICH_P1}, C_P1);
		cfg(5, {PS_FALL, ICH_P2}, C_P2);
		cfg(6, {3'h0, ICH_ARST}, C_AR);
		cfg(6, {AR_FALL, ICH_ARST}, C_AR);
		cfg(4, 6'h0, 7'h0);
		note("presets");
		for (int o = 0; o < 6; o++)
			bus(1'b1, A_OUT0 + 8'(4 * o), 32'((o % 2) * 16 + o + 1));
		@(posedge clk);
		stat <= '{1'b1, 1'b0, 1'b1, 1'b1};
		repeat (4) @(posedge clk);
		`CHK(line, 6'h24)
		`CHK(rout_oe, 6'h3b)
		stat <= '0;
		repeat (4) @(posedge clk);
		`CHK(line, 6'h09)
		`CHK(rout_oe, 6'h37)
		note("outputs");
		bus(1'b1, A_CTRL, 32'h0);
		pulse(0);
		repeat (10) @(posedge clk);
		`CHK(eq.size(), 0)
		note("disable");
		give_verdict();
	end
endmodule
